// ==== src/acsa_pkg.sv ====
/*
 * Shared constants and types for the converter start and bus address control block.
 * Assumes a single 25 MHz system clock and a plain register port from local software.
 */
`default_nettype none
package acsa_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int POWERUP_TIME_NS = 1000;
  // A least time, so the division rounds up.
  localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES_DEFAULT = 50;
  localparam int STRAP_SETTLE = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_UPPER = 8'h04;
  localparam logic [7:0] REG_LOWER = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h18;

  // CONFIG fields.
  localparam int CFG_BUSY_MODE = 0;
  localparam int CFG_ALERT_EN = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h0;
  localparam logic [11:0] UPPER_RESET = 12'hFFF;
  localparam logic [11:0] LOWER_RESET = 12'h000;
  // RESULT fields.
  localparam int RES_VALID = 12;
  // STATUS and MASK bit positions.
  localparam int EV_CONV_DONE = 0;
  localparam int EV_LIMIT = 1;
  localparam int EV_INVALID = 2;
  localparam int EV_ADDR_HIT = 3;
  localparam int EV_COUNT = 4;
  localparam logic [EV_COUNT-1:0] MASK_RESET = 4'h0;
  // STATE fields.
  localparam int ST_BUSY = 0;
  localparam int ST_POWERED = 1;
  localparam int ST_ADDR_LSB = 8;

  // ----------------------------------------------------------------
  // Bus addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_FLOAT = 7'h20;
  localparam logic [6:0] ADDR_V0_GND = 7'h21;
  localparam logic [6:0] ADDR_V0_VDD = 7'h22;
  localparam logic [6:0] ADDR_V1_GND = 7'h23;
  localparam logic [6:0] ADDR_V1_VDD = 7'h24;

  // Address select pin levels: bit 1 set means left unconnected.
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_VDD = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } acsa_bus_req_t;

  typedef enum logic [1:0] {
    ACSA_IDLE,
    ACSA_ADDR,
    ACSA_ACK,
    ACSA_SKIP
  } acsa_link_state_t;
endpackage
`default_nettype wire

// ==== src/acsa_top.sv ====
/*
 * Convert-start edge control, shared open-drain alert/busy output and
 * bus address selection with a minimal address recogniser on the serial link.
 * Assumes the serial clock, serial data, convert start and address select
 * pins are asynchronous to sys_clk, and that conversion data arrive from
 * same-clock converter logic.
 */
//
// Contract
// - Only transitions of the convert start pin cause action, never its steady level.
// - A rising edge of convert start begins a power-up that completes after 1 us.
// - A falling edge of convert start puts the track-and-hold in hold and starts a conversion.
// - One output pin works as either a limit alert or a conversion busy indicator.
// - In alert mode and only when enabled, the pin asserts on a result above upper or below lower.
// - In busy mode the pin stays asserted exactly while a conversion runs; the code asserts and releases it one sys_clk cycle after busy.
// - The shared pin is open-drain: it only pulls low or releases.
// - Serial data is open-drain on both ends, with a pull-up giving the high level.
// - Version 0 answers 010 0001 with select grounded and 010 0010 with select at supply.
// - Version 1 answers 010 0011 with select grounded and 010 0100 with select at supply.
// - Every version answers 010 0000 with the select pin unconnected.
`default_nettype none
module acsa_top #(
  parameter int PART_VERSION = 0,
  parameter int CONV_CYCLES = acsa_pkg::CONV_CYCLES_DEFAULT,
  parameter int DATA_BITS = 12
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire acsa_pkg::acsa_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic irq,
  input wire logic convert_start_pin,
  input wire logic [1:0] bus_address_select_pin,
  input wire logic [DATA_BITS-1:0] conv_data,
  output logic track_hold,
  output logic alert_busy_out,
  output logic alert_busy_oe,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PART_VERSION < 0 || PART_VERSION > 1) begin : g_bad_version
    $error("PART_VERSION must be 0 or 1");
  end
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535 || DATA_BITS < 1 || DATA_BITS > 12) begin : g_bad
    $error("CONV_CYCLES or DATA_BITS out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic cs_prev;
  logic scl_prev;
  logic sda_prev;

  // Two flops per pin; only the second stage is read by logic.
  always_ff @(posedge sys_clk)
  begin
    cs_sync <= {cs_sync[0], convert_start_pin};
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    sel_meta <= bus_address_select_pin;
    sel_sync <= sel_meta;
    cs_prev <= cs_sync[1];
    scl_prev <= scl_sync[1];
    sda_prev <= sda_sync[1];
  end

  // Edges come from comparing the second stage with its delayed copy.
  wire cs_rise = cs_sync[1] & ~cs_prev;
  wire cs_fall = ~cs_sync[1] & cs_prev;
  wire scl_rise = scl_sync[1] & ~scl_prev;
  wire scl_fall = ~scl_sync[1] & scl_prev;
  wire link_start = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  wire link_stop = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // ----------------------------------------------------------------
  // Address strap capture
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt;
  logic [6:0] own_addr;
  logic strap_done;
  logic [6:0] next_addr;

  // The strap is latched once, after the synchroniser has filled past reset.
  always_comb
  begin
    if (sel_sync[1])
      next_addr = acsa_pkg::ADDR_FLOAT;
    else if (PART_VERSION == 0)
      next_addr = (sel_sync == acsa_pkg::SEL_VDD) ? acsa_pkg::ADDR_V0_VDD
                                                   : acsa_pkg::ADDR_V0_GND;
    else
      next_addr = (sel_sync == acsa_pkg::SEL_VDD) ? acsa_pkg::ADDR_V1_VDD
                                                   : acsa_pkg::ADDR_V1_GND;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      own_addr <= acsa_pkg::ADDR_FLOAT;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'(acsa_pkg::STRAP_SETTLE))
      begin
        strap_done <= 1'b1;
        own_addr <= next_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-up and conversion sequencing
  // ----------------------------------------------------------------
  logic powering;
  logic powered;
  logic [4:0] pwr_cnt;
  logic busy;
  logic [15:0] conv_cnt;
  logic result_ok;
  logic [DATA_BITS-1:0] result;
  logic result_valid;
  logic conv_done;
  wire start_conv = cs_fall & ~busy;

  // A rising edge arms the power-up timer; a falling edge holds and converts.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      powering <= 1'b0;
      powered <= 1'b0;
      pwr_cnt <= 5'h00;
    end
    else if (cs_rise && !busy)
    begin
      powering <= 1'b1;
      powered <= 1'b0;
      pwr_cnt <= 5'h00;
    end
    else if (powering)
    begin
      pwr_cnt <= pwr_cnt + 5'h01;
      if (pwr_cnt == 5'(acsa_pkg::POWERUP_CYCLES - 1))
      begin
        powering <= 1'b0;
        powered <= 1'b1;
      end
    end
    else if (conv_done)
      powered <= 1'b0;
  end

  // The conversion is flagged invalid when power-up had not finished: the
  // host broke the minimum high time and we cannot stretch its pulse.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      track_hold <= 1'b0;
      conv_cnt <= 16'h0000;
      conv_done <= 1'b0;
      result_ok <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (start_conv)
      begin
        busy <= 1'b1;
        track_hold <= 1'b1;
        conv_cnt <= 16'h0000;
        result_ok <= powered;
      end
      else if (busy)
      begin
        conv_cnt <= conv_cnt + 16'h0001;
        if (conv_cnt == 16'(CONV_CYCLES - 1))
        begin
          busy <= 1'b0;
          track_hold <= 1'b0;
          conv_done <= 1'b1;
          result <= conv_data;
          result_valid <= result_ok;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit check and shared open-drain pin
  // ----------------------------------------------------------------
  logic [1:0] config_bits;
  logic [DATA_BITS-1:0] upper_limit_value;
  logic [DATA_BITS-1:0] lower_limit_value;
  wire out_of_range = (result > upper_limit_value) || (result < lower_limit_value);
  wire violation_now = conv_done & out_of_range;
  wire alert_level = config_bits[acsa_pkg::CFG_ALERT_EN] & result_valid & out_of_range;
  wire pin_assert = config_bits[acsa_pkg::CFG_BUSY_MODE] ? busy : alert_level;

  // The pin is pulled low when asserted and released otherwise; it never drives high.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      alert_busy_out <= 1'b0;
      alert_busy_oe <= 1'b0;
    end
    else
    begin
      alert_busy_out <= 1'b0;
      alert_busy_oe <= pin_assert;
    end
  end

  // ----------------------------------------------------------------
  // Serial link address recogniser
  // ----------------------------------------------------------------
  acsa_pkg::acsa_link_state_t link_state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic addr_hit;
  wire addr_match = (shift[7:1] == own_addr) & strap_done;

  // Start and stop win over any state; only the address byte is handled here.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      link_state <= acsa_pkg::ACSA_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      addr_hit <= 1'b0;
    end
    else
    begin
      addr_hit <= 1'b0;
      sda_out <= 1'b0;
      if (link_start)
      begin
        link_state <= acsa_pkg::ACSA_ADDR;
        bit_cnt <= 3'h0;
        // Cleared so the first clock fall of a frame never judges the last frame's byte.
        shift <= 8'h00;
        sda_oe <= 1'b0;
      end
      else if (link_stop)
      begin
        link_state <= acsa_pkg::ACSA_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (link_state)
          acsa_pkg::ACSA_IDLE:
            sda_oe <= 1'b0;
          acsa_pkg::ACSA_ADDR:
          begin
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 3'h1;
            end
            if (scl_fall && bit_cnt == 3'h0 && shift != 8'h00)
            begin
              // Eight bits taken; shift[7:1] is the address, shift[0] the direction.
              if (addr_match)
              begin
                sda_oe <= 1'b1;
                addr_hit <= 1'b1;
                link_state <= acsa_pkg::ACSA_ACK;
              end
              else
                link_state <= acsa_pkg::ACSA_SKIP;
            end
          end
          acsa_pkg::ACSA_ACK:
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              link_state <= acsa_pkg::ACSA_SKIP;
            end
          acsa_pkg::ACSA_SKIP:
            sda_oe <= 1'b0;
          default:
            link_state <= acsa_pkg::ACSA_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port, status and interrupt
  // ----------------------------------------------------------------
  logic [acsa_pkg::EV_COUNT-1:0] status;
  logic [acsa_pkg::EV_COUNT-1:0] mask;
  wire [acsa_pkg::EV_COUNT-1:0] events = {addr_hit, conv_done & ~result_ok,
                                          violation_now & result_ok, conv_done};
  wire wr_cfg = bus_req.wr && bus_req.addr == acsa_pkg::REG_CONFIG;
  wire wr_up = bus_req.wr && bus_req.addr == acsa_pkg::REG_UPPER;
  wire wr_lo = bus_req.wr && bus_req.addr == acsa_pkg::REG_LOWER;
  wire wr_mask = bus_req.wr && bus_req.addr == acsa_pkg::REG_MASK;
  wire rd_status = bus_req.rd && bus_req.addr == acsa_pkg::REG_STATUS;
  logic [31:0] rd_mux;

  // Unmapped addresses read as zero and ignore writes.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (bus_req.addr)
      acsa_pkg::REG_CONFIG: rd_mux[1:0] = config_bits;
      acsa_pkg::REG_UPPER: rd_mux[DATA_BITS-1:0] = upper_limit_value;
      acsa_pkg::REG_LOWER: rd_mux[DATA_BITS-1:0] = lower_limit_value;
      acsa_pkg::REG_RESULT:
      begin
        rd_mux[DATA_BITS-1:0] = result;
        rd_mux[acsa_pkg::RES_VALID] = result_valid;
      end
      acsa_pkg::REG_STATUS: rd_mux[acsa_pkg::EV_COUNT-1:0] = status;
      acsa_pkg::REG_MASK: rd_mux[acsa_pkg::EV_COUNT-1:0] = mask;
      acsa_pkg::REG_STATE:
      begin
        rd_mux[acsa_pkg::ST_BUSY] = busy;
        rd_mux[acsa_pkg::ST_POWERED] = powered;
        rd_mux[acsa_pkg::ST_ADDR_LSB +: 7] = own_addr;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Writable registers.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      config_bits <= acsa_pkg::CONFIG_RESET;
      upper_limit_value <= DATA_BITS'(acsa_pkg::UPPER_RESET);
      lower_limit_value <= DATA_BITS'(acsa_pkg::LOWER_RESET);
      mask <= acsa_pkg::MASK_RESET;
    end
    else
    begin
      if (wr_cfg)
        config_bits <= bus_req.wdata[1:0];
      if (wr_up)
        upper_limit_value <= bus_req.wdata[DATA_BITS-1:0];
      if (wr_lo)
        lower_limit_value <= bus_req.wdata[DATA_BITS-1:0];
      if (wr_mask)
        mask <= bus_req.wdata[acsa_pkg::EV_COUNT-1:0];
    end
  end

  // Reading status clears it, but an event in the same cycle still lands.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      status <= '0;
      bus_rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end
    else
    begin
      status <= (rd_status ? '0 : status) | events;
      bus_rdata <= bus_req.rd ? rd_mux : 32'h0000_0000;
      irq <= |(((rd_status ? '0 : status) | events) & mask);
    end
  end
endmodule
`default_nettype wire

// ==== tb/acsa_sva.sv ====
/*
 * Port checker for acsa_top: pin, link and register port timing.
 * Assumes one sys_clk domain and that CONFIG and MASK change only by bus writes.
 */
`default_nettype none
module acsa_sva #(
  parameter int CONV_CYCLES = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire acsa_pkg::acsa_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic irq,
  input wire logic convert_start_pin,
  input wire logic track_hold,
  input wire logic alert_busy_out,
  input wire logic alert_busy_oe,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ----------------------------
  // Shadow state
  // ----------------------------
  logic [1:0] cfg;
  logic [3:0] msk;
  logic [7:0] hold_len;
  logic [3:0] since_fall;
  logic pin_q;
  // Shadows follow writes; the counters measure hold time and edge age.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cfg <= 2'h0;
      msk <= 4'h0;
      hold_len <= 8'h00;
      since_fall <= 4'hF;
      pin_q <= 1'b0;
    end
    else
    begin
      if (bus_req.wr && bus_req.addr == acsa_pkg::REG_CONFIG) cfg <= bus_req.wdata[1:0];
      if (bus_req.wr && bus_req.addr == acsa_pkg::REG_MASK) msk <= bus_req.wdata[3:0];
      hold_len <= track_hold ? hold_len + 8'h01 : 8'h00;
      pin_q <= convert_start_pin;
      // Saturates so a long quiet spell never looks like a fresh edge.
      since_fall <= (pin_q && !convert_start_pin) ? 4'h0 :
        ((since_fall == 4'hF) ? 4'hF : since_fall + 4'h1);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_od_alert;
    alert_busy_out == 1'b0;
  endproperty
  a_od_alert: assert property (p_od_alert) else $error("alert pin driven high");
  property p_od_sda;
    sda_out == 1'b0;
  endproperty
  a_od_sda: assert property (p_od_sda) else $error("data line driven high");
  property p_ack_low;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("data pulled while clock high");
  property p_start;
    $rose(track_hold) |-> since_fall <= 4'h6;
  endproperty
  a_start: assert property (p_start) else $error("hold without a recent fall");
  property p_conv_len;
    $fell(track_hold) |-> hold_len == CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("hold length wrong");
  property p_busy_on;
    cfg == 2'h1 && $rose(track_hold) |-> ##[0:1] alert_busy_oe;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy not shown");
  property p_busy_off;
    cfg == 2'h1 && $fell(track_hold) |-> ##[0:2] !alert_busy_oe;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy not released");
  property p_quiet;
    (cfg == 2'h0) [*3] |-> !alert_busy_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alert while disabled");
  property p_rdata;
    !$past(bus_req.rd) |-> bus_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  property p_irq;
    (msk == 4'h0) [*2] |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule

bind acsa_top acsa_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.sys_clk, .resetn, .bus_req,
  .bus_rdata, .irq, .convert_start_pin, .track_hold, .alert_busy_out, .alert_busy_oe,
  .scl_in, .sda_out, .sda_oe);
`default_nettype wire

// ==== tb/acsa_host.sv ====
/*
 * Two-wire bus host: sends START, an address byte and reads the acknowledge.
 * Assumes the bench resolves both lines from the low-drive enables with pull-ups.
 */
`default_nettype none
module acsa_host (
  input wire logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines released at rest; the clock stands still between frames.
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Quarter steps of 80 ns give a 320 ns bus clock; data moves only while the clock is low, except at START and STOP.
  task automatic frame(input logic [6:0] addr, output logic ack);
    logic [7:0] bv;
    bv = {addr, 1'b0};
    #13 sda_low = 1'b1;
    #80 scl_low = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      #80 sda_low = !bv[i];
      #80 scl_low = 1'b0;
      #160 scl_low = 1'b1;
    end
    #80 sda_low = 1'b0;
    #160 scl_low = 1'b0;
    #80 ack = !sda_line;
    #80 scl_low = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #160;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for acsa_top: two part versions share every input pin and the bus.
 * Assumes the pull-ups on both link lines are modelled here from the enables.
 */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------
  // Wiring
  // ----------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  acsa_pkg::acsa_bus_req_t bus_req = '0;
  logic pin = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [11:0] conv_data = 12'h000;
  logic [31:0] rd0, rd1;
  logic irq, th, abo, oe, so0, oe0, oe1, scl_low, sda_low, scl, sda;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // Open-drain lines: high unless some party pulls low.
  assign scl = !scl_low;
  assign sda = !(sda_low || oe0 || oe1);
  always #20 sys_clk = !sys_clk;
  acsa_top #(.PART_VERSION(0), .CONV_CYCLES(12)) dut (.sys_clk, .resetn, .bus_req,
    .bus_rdata(rd0), .irq, .convert_start_pin(pin), .bus_address_select_pin(sel),
    .conv_data, .track_hold(th), .alert_busy_out(abo), .alert_busy_oe(oe), .scl_in(scl),
    .sda_in(sda), .sda_out(so0), .sda_oe(oe0));
  acsa_top #(.PART_VERSION(1), .CONV_CYCLES(12)) dut1 (.sys_clk, .resetn, .bus_req,
    .bus_rdata(rd1), .irq(), .convert_start_pin(pin), .bus_address_select_pin(sel),
    .conv_data, .track_hold(), .alert_busy_out(), .alert_busy_oe(), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(oe1));
  acsa_host host (.sda_line(sda), .scl_low, .sda_low);
  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short; the tests need well under a tenth of this.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus_req <= {a, d, 2'b10};
    @(posedge sys_clk) bus_req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input bit v1 = 0);
    @(posedge sys_clk) bus_req <= {a, 32'h0, 2'b01};
    @(posedge sys_clk) bus_req.rd <= 1'b0;
    #1 d = v1 ? rd1 : rd0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic wt(input logic v);
    for (int i = 0; i < 20 && th !== v; i++) @(posedge sys_clk);
    chk("track_hold", v, th);
  endtask
  task automatic pulse(input int hi);
    @(posedge sys_clk) pin <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    pin <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge sys_clk) resetn <= 1'b0;
    sel <= s;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_regs;
    wr(8'h1C, 32'hFFFFFFFF);
    rc(8'h1C, 32'h0, "unmapped");
    rc(acsa_pkg::REG_CONFIG, 32'h0, "config");
    rc(acsa_pkg::REG_UPPER, 32'hFFF, "upper");
    rc(acsa_pkg::REG_LOWER, 32'h0, "lower");
    rc(acsa_pkg::REG_MASK, 32'h0, "mask");
    $display("test regs done");
  endtask
  // Grounded, supply and unconnected strap on both versions; a foreign address gets no ack.
  task automatic t_addr;
    logic [1:0] s[3] = '{2'h0, 2'h1, 2'h2};
    logic [6:0] a0[3] = '{7'h21, 7'h22, 7'h20};
    logic [6:0] a1[3] = '{7'h23, 7'h24, 7'h20};
    logic [31:0] d;
    logic ack;
    for (int k = 0; k < 3; k++)
    begin
      do_reset(s[k]);
      rd(acsa_pkg::REG_STATE, d);
      chk("addr v0", a0[k], d[14:8]);
      rd(acsa_pkg::REG_STATE, d, 1);
      chk("addr v1", a1[k], d[14:8]);
      host.frame(a0[k], ack);
      chk("ack v0", 1'b1, ack);
      chk("data level", 1'b0, so0);
      host.frame(a1[k], ack);
      chk("ack v1", 1'b1, ack);
      host.frame(7'h30, ack);
      chk("no ack", 1'b0, ack);
    end
    $display("test addr done");
  endtask
  task automatic t_conv;
    logic [31:0] d;
    wr(acsa_pkg::REG_CONFIG, 32'h1);
    wr(acsa_pkg::REG_MASK, 32'hF);
    rd(acsa_pkg::REG_STATUS, d);
    @(posedge sys_clk) conv_data <= 12'h5A5;
    pulse(30);
    wt(1'b1);
    @(posedge sys_clk) chk("busy pin", 1'b1, oe);
    pulse(1);
    wt(1'b0);
    repeat (2) @(posedge sys_clk);
    chk("busy pin", 1'b0, oe);
    chk("irq", 1'b1, irq);
    rc(acsa_pkg::REG_RESULT, 32'h15A5, "result");
    rd(acsa_pkg::REG_STATUS, d);
    chk("done", 1'b1, d[0]);
    repeat (2) @(posedge sys_clk);
    chk("irq", 1'b0, irq);
    $display("test conv done");
  endtask
  task automatic t_short;
    logic [31:0] d;
    pulse(5);
    wt(1'b1);
    wt(1'b0);
    rd(acsa_pkg::REG_RESULT, d);
    chk("valid", 1'b0, d[12]);
    rd(acsa_pkg::REG_STATUS, d);
    chk("invalid", 1'b1, d[2]);
    $display("test short done");
  endtask
  // Above the upper limit the alert pulls; a masked status keeps the interrupt low.
  task automatic t_alert;
    logic [31:0] d;
    wr(acsa_pkg::REG_CONFIG, 32'h2);
    wr(acsa_pkg::REG_UPPER, 32'h800);
    @(posedge sys_clk) conv_data <= 12'h900;
    pulse(30);
    wt(1'b1);
    wt(1'b0);
    repeat (3) @(posedge sys_clk);
    chk("alert", 1'b1, oe);
    chk("alert level", 1'b0, abo);
    chk("irq", 1'b1, irq);
    wr(acsa_pkg::REG_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq", 1'b0, irq);
    rd(acsa_pkg::REG_STATUS, d);
    chk("limit", 1'b1, d[1]);
    @(posedge sys_clk) conv_data <= 12'h400;
    pulse(30);
    wt(1'b1);
    wt(1'b0);
    repeat (3) @(posedge sys_clk);
    chk("alert", 1'b0, oe);
    $display("test alert done");
  endtask
  // Main sequence.
  initial
  begin
    do_reset(2'h0);
    t_regs;
    t_addr;
    t_conv;
    t_short;
    t_alert;
    finish_test;
  end
endmodule
`default_nettype wire
